// *** src/rpmsi_pkg.sv ***
// Constants and types shared by the root port message interrupt block.
// Assumes configuration accesses arrive as aligned dwords with byte enables.
package rpmsi_pkg;

    // Printed byte offsets of the three registers
    localparam logic [7:0] CTRL_OFF = 8'h5a;
    localparam logic [7:0] ADDR_OFF = 8'h5c;
    localparam logic [7:0] DATA_OFF = 8'h60;
    // Byte lane of the dword that holds the low control byte
    localparam int CTRL_LANE = 2;

    // Control field positions and fixed values
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_REQ_LO = 1;
    localparam int CTRL_GRANT_LO = 4;
    localparam int CTRL_WIDE_BIT = 7;
    localparam logic WIDE_CAP = 1'b0;
    localparam logic [2:0] REQ_COUNT = 3'h1;
    localparam logic [2:0] GRANT_RST = 3'h0;

    // Address field positions and reset values
    localparam int ADDR_UPPER_LO = 20;
    localparam int ADDR_TARGET_LO = 12;
    localparam int ADDR_EXT_LO = 4;
    localparam int ADDR_HINT_BIT = 3;
    localparam int ADDR_MODE_BIT = 2;
    localparam logic [11:0] ADDR_UPPER_RST = 12'hfee;
    localparam logic [7:0] ADDR_TARGET_RST = 8'h00;
    localparam logic [7:0] ADDR_EXT_RST = 8'h00;

    // Data field positions and reset values
    localparam int DATA_TK_BIT = 15;
    localparam int DATA_LVL_BIT = 14;
    localparam int DATA_SPARE_LO = 11;
    localparam int DATA_DISP_LO = 8;
    localparam logic [7:0] DATA_VEC_RST = 8'h00;
    localparam logic [2:0] DATA_FIELD3_RST = 3'h0;

    // Delivery kind encodings
    localparam logic [2:0] DISP_FIXED = 3'h0;
    localparam logic [2:0] DISP_LOWEST = 3'h1;
    localparam logic [2:0] DISP_SYSMGT = 3'h2;
    localparam logic [2:0] DISP_NMI = 3'h4;
    localparam logic [2:0] DISP_INIT = 3'h5;
    localparam logic [2:0] DISP_EXT = 3'h7;

    // Sender states
    typedef enum logic {RPMSI_IDLE, RPMSI_SEND} rpmsi_state_t;

endpackage

// *** src/rpmsi_cfg_if.sv ***
// Programmed message settings passed from the register file to the sender.
// Assumes both ends share one clock; all signals except two_msgs, a compare of the granted count, are register outputs.
`timescale 1ns/1ps
`default_nettype none
interface rpmsi_cfg_if;
    logic enable;
    logic two_msgs;
    logic [31:0] addr_word;
    logic [15:0] data_word;

    modport regs (output enable, output two_msgs, output addr_word, output data_word);
    modport sender (input enable, input two_msgs, input addr_word, input data_word);
endinterface
`default_nettype wire

// *** src/rpmsi_sender.sv ***
// Pending event flags and the interrupt write message launcher.
// Assumes the fabric holds msg_ready meaningful only while msg_valid is high.
`timescale 1ns/1ps
`default_nettype none
module rpmsi_sender
    import rpmsi_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    rpmsi_cfg_if.sender cfg,
    input wire logic evt_norm,
    input wire logic evt_err,
    input wire logic norm_evt_en,
    input wire logic err_evt_en,
    input wire logic line_state,
    input wire logic msg_ready,
    output logic msg_valid,
    output logic [31:0] msg_addr,
    output logic [31:0] msg_data,
    output logic msg_num
);

    rpmsi_state_t state;
    logic pend_norm;
    logic pend_err;
    logic launch;
    logic launch_err;
    logic next_num;

    // Launch when idle and enabled, error events first
    assign launch = (state == RPMSI_IDLE) && cfg.enable && (pend_norm || pend_err);
    assign launch_err = launch && pend_err;
    assign next_num = launch_err && cfg.two_msgs;

    ////////////////////////////////////////////////////////////////////////
    // Pending flags: a new event wins over the clear of a launch
    always_ff @(posedge clock)
    begin
        if (!rst_n || !cfg.enable)
        begin
            pend_norm <= 1'b0;
            pend_err <= 1'b0;
        end
        else
        begin
            pend_err <= (pend_err && !launch_err) || (evt_err && err_evt_en);
            pend_norm <= (pend_norm && !(launch && !launch_err)) || (evt_norm && norm_evt_en);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Message handshake and frozen message contents
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state <= RPMSI_IDLE;
            msg_valid <= 1'b0;
            msg_addr <= 32'h0;
            msg_data <= 32'h0;
            msg_num <= 1'b0;
        end
        else
        begin
            case (state)
                RPMSI_IDLE:
                begin
                    if (launch)
                    begin
                        state <= RPMSI_SEND;
                        msg_valid <= 1'b1;
                        msg_addr <= {cfg.addr_word[31:2], 2'b00};
                        msg_data[31:16] <= 16'h0;
                        msg_data[15] <= cfg.data_word[DATA_TK_BIT];
                        msg_data[14] <= cfg.data_word[DATA_TK_BIT] ? line_state : 1'b1;
                        msg_data[13:8] <= cfg.data_word[13:8];
                        msg_data[7:0] <= cfg.data_word[7:0] + {7'h0, next_num};
                        msg_num <= next_num;
                    end
                end
                RPMSI_SEND:
                begin
                    if (msg_ready)
                    begin
                        state <= RPMSI_IDLE;
                        msg_valid <= 1'b0;
                    end
                end
                default:
                begin
                    state <= RPMSI_IDLE;
                    msg_valid <= 1'b0;
                end
            endcase
        end
    end

    a_msg_held: assert property (@(posedge clock) disable iff (!rst_n)
        msg_valid && !msg_ready |=> msg_valid && $stable(msg_data) && $stable(msg_addr))
        else $error("message changed before it was taken");

endmodule // rpmsi_sender
`default_nettype wire

// *** src/rpmsi_message_generator.sv ***
// Message interrupt registers and message generation for one root port.
// Assumes configuration reads and writes come from the core clock domain,
// one access per cycle, with dword aligned cfg_addr and byte enables.
//
// Notes on behaviour
// - Wide address capability reads zero; addresses 32-bit
// - Two granted: normal uses 0, errors use 1
// - One granted: all events use message 0
// - Requested count field reads fixed encoding 001
// - Disabled: no messages, legacy line used instead
// - Enabled: send messages for enabled port events
// - Upper twelve address bits writable, reset fee
// - Target id field, reset zero, routes interrupt
// - Extended target field stored, placed in address
// - Address bit 3 redirect hint, reset zero
// - Address bit 2 mode; bits 1:0 reserved
// - Data bit 15 selects edge or level
// - Edge mode: level bit ignored, always assert
// - Level mode: level bit follows interrupt input
// - Data bits 13:11 plain storage; 31:16 reserved
// - Each interrupt is one memory write message
`timescale 1ns/1ps
`default_nettype none
module rpmsi_message_generator
    import rpmsi_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_rvalid,
    input wire logic evt_norm,
    input wire logic evt_err,
    input wire logic norm_evt_en,
    input wire logic err_evt_en,
    input wire logic line_state,
    output logic legacy_irq,
    input wire logic msg_ready,
    output logic msg_valid,
    output logic [31:0] msg_addr,
    output logic [31:0] msg_data,
    output logic msg_num
);

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    logic signalled_irq_enable;
    logic [2:0] granted_msg_count;
    logic [11:0] addr_upper_bits;
    logic [7:0] target_id;
    logic [7:0] target_id_ext;
    logic redirect_hint;
    logic target_addr_mode;
    logic trigger_kind;
    logic assert_level;
    logic [2:0] data_spare;
    logic [2:0] dispatch_kind;
    logic [7:0] vector_number;
    logic [31:0] next_addr;
    logic [31:0] next_data;
    logic [31:0] next_ctrl;
    logic wr_ctrl;
    logic wr_addr;
    logic wr_data;

    rpmsi_cfg_if cfg_bus ();

    ////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Dword hit for a printed byte offset
    function automatic logic dw_hit(input logic [7:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction

    // Byte enables widened to a bit mask
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        logic [31:0] m;
        m = 32'h0;
        for (int i = 0; i < 4; i++)
        begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction

    // Merge written bytes into a current word
    function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] wd, input logic [3:0] be);
        return (cur & ~be_mask(be)) | (wd & be_mask(be));
    endfunction

    // Control register image
    function automatic logic [15:0] ctrl_word(input logic en, input logic [2:0] grant);
        logic [15:0] w;
        w = 16'h0;
        w[CTRL_WIDE_BIT] = WIDE_CAP;
        w[CTRL_GRANT_LO +: 3] = grant;
        w[CTRL_REQ_LO +: 3] = REQ_COUNT;
        w[CTRL_EN_BIT] = en;
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Current register images
    logic [31:0] addr_image;
    logic [31:0] data_image;
    logic [15:0] ctrl_image;

    // Address image; reserved low bits read zero
    always_comb
    begin
        addr_image = 32'h0;
        addr_image[ADDR_UPPER_LO +: 12] = addr_upper_bits;
        addr_image[ADDR_TARGET_LO +: 8] = target_id;
        addr_image[ADDR_EXT_LO +: 8] = target_id_ext;
        addr_image[ADDR_HINT_BIT] = redirect_hint;
        addr_image[ADDR_MODE_BIT] = target_addr_mode;
    end

    // Data image; upper half reserved and zero
    always_comb
    begin
        data_image = 32'h0;
        data_image[DATA_TK_BIT] = trigger_kind;
        data_image[DATA_LVL_BIT] = assert_level;
        data_image[DATA_SPARE_LO +: 3] = data_spare;
        data_image[DATA_DISP_LO +: 3] = dispatch_kind;
        data_image[7:0] = vector_number;
    end

    assign ctrl_image = ctrl_word(signalled_irq_enable, granted_msg_count);

    // Write decode; address and data next values merged, control next value taken as written
    assign wr_ctrl = cfg_wr && dw_hit(cfg_addr, CTRL_OFF) && cfg_be[CTRL_LANE];
    assign wr_addr = cfg_wr && dw_hit(cfg_addr, ADDR_OFF);
    assign wr_data = cfg_wr && dw_hit(cfg_addr, DATA_OFF);
    assign next_addr = merge(addr_image, cfg_wdata, cfg_be);
    assign next_data = merge(data_image, cfg_wdata, cfg_be);
    assign next_ctrl = cfg_wdata;

    ////////////////////////////////////////////////////////////////////////
    // Control register: enable and granted count are writable
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            signalled_irq_enable <= 1'b0;
            granted_msg_count <= GRANT_RST;
        end
        else if (wr_ctrl)
        begin
            signalled_irq_enable <= next_ctrl[16 + CTRL_EN_BIT];
            granted_msg_count <= next_ctrl[16 + CTRL_GRANT_LO +: 3];
        end
    end

    // Address register fields
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            addr_upper_bits <= ADDR_UPPER_RST;
            target_id <= ADDR_TARGET_RST;
            target_id_ext <= ADDR_EXT_RST;
            redirect_hint <= 1'b0;
            target_addr_mode <= 1'b0;
        end
        else if (wr_addr)
        begin
            addr_upper_bits <= next_addr[ADDR_UPPER_LO +: 12];
            target_id <= next_addr[ADDR_TARGET_LO +: 8];
            target_id_ext <= next_addr[ADDR_EXT_LO +: 8];
            redirect_hint <= next_addr[ADDR_HINT_BIT];
            target_addr_mode <= next_addr[ADDR_MODE_BIT];
        end
    end

    // Data register fields; reserved delivery codes are stored as written
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            trigger_kind <= 1'b0;
            assert_level <= 1'b0;
            data_spare <= DATA_FIELD3_RST;
            dispatch_kind <= DISP_FIXED;
            vector_number <= DATA_VEC_RST;
        end
        else if (wr_data)
        begin
            trigger_kind <= next_data[DATA_TK_BIT];
            assert_level <= next_data[DATA_LVL_BIT];
            data_spare <= next_data[DATA_SPARE_LO +: 3];
            dispatch_kind <= next_data[DATA_DISP_LO +: 3];
            vector_number <= next_data[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port: answer one cycle after the request, unmapped reads zero
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            cfg_rdata <= 32'h0;
            cfg_rvalid <= 1'b0;
        end
        else
        begin
            cfg_rvalid <= cfg_rd;
            if (cfg_rd)
            begin
                if (dw_hit(cfg_addr, CTRL_OFF))
                begin
                    cfg_rdata <= {ctrl_image, 16'h0};
                end
                else if (dw_hit(cfg_addr, ADDR_OFF))
                begin
                    cfg_rdata <= addr_image;
                end
                else if (dw_hit(cfg_addr, DATA_OFF))
                begin
                    cfg_rdata <= data_image;
                end
                else
                begin
                    cfg_rdata <= 32'h0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Legacy line: follows the interrupt input only while messages are off
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            legacy_irq <= 1'b0;
        end
        else
        begin
            legacy_irq <= !signalled_irq_enable && line_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Settings handed to the sender
    assign cfg_bus.enable = signalled_irq_enable;
    assign cfg_bus.two_msgs = granted_msg_count != GRANT_RST;
    assign cfg_bus.addr_word = addr_image;
    assign cfg_bus.data_word = data_image[15:0];

    // Message launcher
    rpmsi_sender u_sender (
        .clock(clock),
        .rst_n(rst_n),
        .cfg(cfg_bus.sender),
        .evt_norm(evt_norm),
        .evt_err(evt_err),
        .norm_evt_en(norm_evt_en),
        .err_evt_en(err_evt_en),
        .line_state(line_state),
        .msg_ready(msg_ready),
        .msg_valid(msg_valid),
        .msg_addr(msg_addr),
        .msg_data(msg_data),
        .msg_num(msg_num)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_wide_cap_zero: assert property (@(posedge clock) disable iff (!rst_n)
        cfg_rd && dw_hit(cfg_addr, CTRL_OFF) |=> cfg_rvalid && !cfg_rdata[16 + CTRL_WIDE_BIT])
        else $error("wide address capability read as set");

    a_req_count_fixed: assert property (@(posedge clock) disable iff (!rst_n)
        cfg_rd && dw_hit(cfg_addr, CTRL_OFF) |=> cfg_rdata[16 + CTRL_REQ_LO +: 3] == REQ_COUNT)
        else $error("requested count not 001");

    a_upper_reset: assert property (@(posedge clock)
        !rst_n |=> addr_upper_bits == ADDR_UPPER_RST && target_id == ADDR_TARGET_RST && !redirect_hint)
        else $error("address reset value wrong");

    a_no_msg_off: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(msg_valid) |-> $past(signalled_irq_enable))
        else $error("message sent while disabled");

    a_legacy_off: assert property (@(posedge clock) disable iff (!rst_n)
        legacy_irq |-> $past(!signalled_irq_enable && line_state))
        else $error("legacy line while messages enabled");

    a_event_sent: assert property (@(posedge clock) disable iff (!rst_n)
        signalled_irq_enable && !msg_valid && evt_norm && norm_evt_en && !evt_err
        ##1 signalled_irq_enable |-> ##[0:1] msg_valid)
        else $error("enabled event not sent");

    a_error_num: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(msg_valid) && msg_num |-> $past(granted_msg_count) != 3'h0)
        else $error("message 1 used with one granted");

    a_vector_form: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(msg_valid) |-> msg_data[7:0] == $past(vector_number) + {7'h0, msg_num})
        else $error("message vector wrong");

    a_edge_assert: assert property (@(posedge clock) disable iff (!rst_n)
        msg_valid && !msg_data[15] |-> msg_data[14])
        else $error("edge message not assert");

    a_level_follow: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(msg_valid) && msg_data[15] |-> msg_data[14] == $past(line_state))
        else $error("level bit not following input");

    a_addr_format: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(msg_valid) |-> msg_addr[1:0] == 2'b00 && msg_addr[31:4] == $past(addr_image[31:4]))
        else $error("message address wrong");

    a_data_reserved: assert property (@(posedge clock) disable iff (!rst_n)
        msg_valid |-> msg_data[31:16] == 16'h0)
        else $error("reserved data bits set");

    a_trigger_copy: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(msg_valid) |-> msg_data[DATA_TK_BIT] == $past(trigger_kind))
        else $error("trigger kind not sent as programmed");

    a_kind_copy: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(msg_valid) |-> msg_data[DATA_DISP_LO +: 3] == $past(dispatch_kind))
        else $error("delivery kind not sent as programmed");

    a_target_route: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(msg_valid) |-> msg_addr[ADDR_EXT_LO +: 16] == $past({target_id, target_id_ext}))
        else $error("target fields not in message address");

    a_disabled_quiet: assert property (@(posedge clock) disable iff (!rst_n)
        !signalled_irq_enable && !msg_valid |=> !msg_valid)
        else $error("message launched while disabled");

    a_legacy_follow: assert property (@(posedge clock) disable iff (!rst_n)
        !signalled_irq_enable && line_state |=> legacy_irq)
        else $error("legacy line not raised while disabled");

    a_outputs_reset: assert property (@(posedge clock)
        !rst_n |=> !msg_valid && !legacy_irq && !cfg_rvalid)
        else $error("outputs not cleared by reset");

endmodule // rpmsi_message_generator
`default_nettype wire

// *** sim/rpmsi_fabric_model.sv ***
// Interrupt fabric model that accepts message writes from the root port.
// Assumes the root port clock; stall sets how many cycles each write waits.
`timescale 1ns/1ps
`default_nettype none
module rpmsi_fabric_model
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [3:0] stall,
    input wire logic msg_valid,
    input wire logic [31:0] msg_addr,
    input wire logic [31:0] msg_data,
    input wire logic msg_num,
    output logic msg_ready,
    output logic [31:0] got_addr,
    output logic [31:0] got_data,
    output logic got_num,
    output logic [7:0] got_count
);
    logic [3:0] wait_cnt;
    ////////////////////////////////////////////////////////////////
    // Accept after stall cycles; low while no write is offered
    assign msg_ready = msg_valid && (wait_cnt == stall);
    // Count cycles the current write has waited
    always_ff @(posedge clock)
    begin
        if (!rst_n || !msg_valid || msg_ready)
        begin
            wait_cnt <= 4'h0;
        end
        else
        begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
    // Take each write; address routes it, data names the interrupt
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            got_count <= 8'h00;
        end
        else if (msg_valid && msg_ready)
        begin
            got_addr <= msg_addr;
            got_data <= msg_data;
            got_num <= msg_num;
            got_count <= got_count + 8'h01;
        end
    end
endmodule // rpmsi_fabric_model
`default_nettype wire

// *** sim/rpmsi_message_generator_test.sv ***
// Self-checking bench for the root port message interrupt block.
// Assumes the fabric model answers writes; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module rpmsi_message_generator_test;
    import rpmsi_pkg::*;
    typedef struct packed {logic [2:0] grant; logic tk; logic line; logic err;
        logic [2:0] kind; logic [7:0] vec; logic exp_num; logic exp_lvl;} rpmsi_row_t;
    logic clock, rst_n, cfg_wr, cfg_rd, cfg_rvalid, evt_norm, evt_err, norm_evt_en, err_evt_en;
    logic line_state, legacy_irq, msg_ready, msg_valid, msg_num, got_num;
    logic [7:0] cfg_addr, got_count;
    logic [3:0] cfg_be, stall;
    logic [31:0] cfg_wdata, cfg_rdata, msg_addr, msg_data, got_addr, got_data, a, d;
    rpmsi_row_t rows [8];
    rpmsi_row_t r;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int c;
    ////////////////////////////////////////////////////////////////
    rpmsi_message_generator u_rpmsi_message_generator (.clock(clock), .rst_n(rst_n),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
        .evt_norm(evt_norm), .evt_err(evt_err), .norm_evt_en(norm_evt_en),
        .err_evt_en(err_evt_en), .line_state(line_state), .legacy_irq(legacy_irq),
        .msg_ready(msg_ready), .msg_valid(msg_valid), .msg_addr(msg_addr),
        .msg_data(msg_data), .msg_num(msg_num));
    rpmsi_fabric_model u_rpmsi_fabric_model (.clock(clock), .rst_n(rst_n), .stall(stall),
        .msg_valid(msg_valid), .msg_addr(msg_addr), .msg_data(msg_data), .msg_num(msg_num),
        .msg_ready(msg_ready), .got_addr(got_addr), .got_data(got_data), .got_num(got_num),
        .got_count(got_count));
    ////////////////////////////////////////////////////////////////
    // Clock at 50 ns period and the hang limit
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            num_errors++;
            $display("[ERR] %0t run took too long", $time);
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////
    // Compare, bus cycles and event pulses
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task cfg_write(input logic [7:0] ad, input logic [3:0] be, input logic [31:0] wd);
        @(negedge clock);
        cfg_wr = 1'b1;
        cfg_addr = ad;
        cfg_be = be;
        cfg_wdata = wd;
        @(negedge clock);
        cfg_wr = 1'b0;
    endtask
    task rd_chk(input logic [7:0] ad, input logic [31:0] e);
        @(negedge clock);
        cfg_rd = 1'b1;
        cfg_addr = ad;
        @(negedge clock);
        cfg_rd = 1'b0;
        chk({31'h0, cfg_rvalid}, 32'h1, "read answer");
        chk(cfg_rdata, e, "read data");
    endtask
    task fire(input logic err);
        @(negedge clock);
        evt_err = err;
        evt_norm = ~err;
        @(negedge clock);
        evt_err = 1'b0;
        evt_norm = 1'b0;
    endtask
    task wait_msg(input int n);
        for (int k = 0; k < 40 && got_count !== 8'(n); k++)
            @(negedge clock);
        chk({24'h0, got_count}, 32'(n), "message count");
    endtask
    task ctrl(input logic en, input logic [2:0] g);
        cfg_write(8'h58, 4'h4, {8'h00, 1'b1, g, 3'h6, en, 16'h0000});
    endtask
    task reset_chk;
        rd_chk(8'h58, 32'h0002_0000);
        rd_chk(8'h5c, 32'hfee0_0000);
        rd_chk(8'h60, 32'h0000_0000);
        chk({31'h0, msg_valid}, 32'h0, "valid after reset");
        cfg_write(8'h40, 4'hf, 32'hffff_ffff);
        cfg_write(8'h58, 4'h3, 32'hffff_ffff);
        rd_chk(8'h40, 32'h0);
        rd_chk(8'h58, 32'h0002_0000);
        $display("test reset done");
    endtask
    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // Main sequence: reset, table of messages, then awkward cases
    initial
    begin
        {rst_n, cfg_wr, cfg_rd, evt_norm, evt_err, line_state} = 6'h00;
        {norm_evt_en, err_evt_en} = 2'h3;
        {cfg_addr, cfg_be, cfg_wdata, stall} = '0;
        rows = '{'{3'h1, 1'b0, 1'b0, 1'b0, 3'h0, 8'h10, 1'b0, 1'b1},
                 '{3'h1, 1'b0, 1'b1, 1'b1, 3'h1, 8'h10, 1'b1, 1'b1},
                 '{3'h0, 1'b0, 1'b0, 1'b1, 3'h2, 8'hff, 1'b0, 1'b1},
                 '{3'h0, 1'b1, 1'b0, 1'b0, 3'h4, 8'h33, 1'b0, 1'b0},
                 '{3'h1, 1'b1, 1'b1, 1'b1, 3'h5, 8'hfe, 1'b1, 1'b1},
                 '{3'h1, 1'b1, 1'b0, 1'b0, 3'h7, 8'h80, 1'b0, 1'b0},
                 '{3'h2, 1'b0, 1'b0, 1'b1, 3'h3, 8'h7f, 1'b1, 1'b1},
                 '{3'h0, 1'b1, 1'b1, 1'b1, 3'h6, 8'h01, 1'b0, 1'b1}};
        repeat (20) @(negedge clock);
        rst_n = 1'b1;
        chk({31'h0, legacy_irq}, 32'h0, "legacy after reset");
        reset_chk();
        for (int i = 0; i < 8; i++)
        begin
            r = rows[i];
            stall = 4'(i);
            ctrl(1'b1, r.grant);
            rd_chk(8'h58, {8'h00, 1'b0, r.grant, 3'h1, 1'b1, 16'h0});
            a = {12'hfe0 + 12'(i), 8'(8'h11 * i), 8'(8'ha5 ^ i), i[1], i[0], 2'h3};
            cfg_write(8'h5c, 4'hf, a);
            rd_chk(8'h5c, {a[31:2], 2'h0});
            d = {16'hffff, r.tk, r.tk & ~r.line, 3'h5, r.kind, r.vec};
            cfg_write(8'h60, 4'hf, d);
            rd_chk(8'h60, {16'h0, d[15:0]});
            line_state = r.line;
            c = got_count;
            fire(r.err);
            wait_msg(c + 1);
            chk(got_addr, {a[31:2], 2'h0}, "address");
            d = {16'h0, r.tk, r.exp_lvl, 3'h5, r.kind, r.vec + {7'h0, r.exp_num}};
            chk(got_data, d, "data");
            chk({31'h0, got_num}, {31'h0, r.exp_num}, "number");
            $display("test row %0d done", i);
        end
        // Disabled: no messages, legacy line follows the input
        ctrl(1'b0, 3'h1);
        line_state = 1'b1;
        c = got_count;
        fire(1'b1);
        fire(1'b0);
        repeat (10) @(negedge clock);
        chk({24'h0, got_count}, 32'(c), "disabled count");
        chk({31'h0, legacy_irq}, 32'h1, "legacy");
        // Enabled but port events masked
        {norm_evt_en, err_evt_en} = 2'h0;
        ctrl(1'b1, 3'h1);
        fire(1'b1);
        fire(1'b0);
        repeat (10) @(negedge clock);
        chk({24'h0, got_count}, 32'(c), "masked count");
        chk({31'h0, legacy_irq}, 32'h0, "legacy off");
        $display("test disabled done");
        // Both kinds at once on a slow fabric: error first, repeats merge
        {norm_evt_en, err_evt_en} = 2'h3;
        stall = 4'h6;
        @(negedge clock);
        {evt_norm, evt_err} = 2'h3;
        @(negedge clock);
        evt_err = 1'b0;
        @(negedge clock);
        evt_norm = 1'b0;
        wait_msg(c + 1);
        chk({31'h0, got_num}, 32'h1, "first number");
        wait_msg(c + 2);
        chk({31'h0, got_num}, 32'h0, "second number");
        repeat (15) @(negedge clock);
        chk({24'h0, got_count}, 32'(c + 2), "merged count");
        $display("test order done");
        // Second reset in mid-run
        rst_n = 1'b0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        reset_chk();
        report_and_stop();
    end
endmodule // rpmsi_message_generator_test
`default_nettype wire
